// >>> enpcu_map.vh
// Offsets, field positions, command codes and address map of the command unit
`ifndef ENPCU_MAP_VH
`define ENPCU_MAP_VH

// Register byte offsets on APB
`define ENPCU_OFS_RESET     8'h00
`define ENPCU_OFS_KEY       8'h04
`define ENPCU_OFS_STATUS    8'h08
`define ENPCU_OFS_CMD       8'h0C
`define ENPCU_OFS_CTL_A     8'h10
`define ENPCU_OFS_DATA      8'h14

// Field positions and reset values
`define ENPCU_ST_EN_BIT     0
`define ENPCU_ST_BUSY_BIT   1
`define ENPCU_ST_REFUSED_BIT 2
`define ENPCU_CTL_A_EX_BIT  0
`define ENPCU_RESET_SIG     8'h59
`define ENPCU_RESET_RST     8'h00
`define ENPCU_CMD_RST       7'h00
`define ENPCU_DATA_RST      32'h0000_0000

// Trigger classes
`define ENPCU_TRG_NONE      2'h0
`define ENPCU_TRG_EXEC      2'h1
`define ENPCU_TRG_READ      2'h2
`define ENPCU_TRG_WRITE     2'h3

// Command codes
`define ENPCU_C_NOP         7'h00
`define ENPCU_C_CHIP_ERASE  7'h40
`define ENPCU_C_READ_STORE  7'h43
`define ENPCU_C_FBUF_LOAD   7'h23
`define ENPCU_C_FBUF_ERASE  7'h26
`define ENPCU_C_FPG_ERASE   7'h2B
`define ENPCU_C_FPG_WRITE   7'h2E
`define ENPCU_C_FPG_EW      7'h2F
`define ENPCU_C_FLASH_CRC   7'h78
`define ENPCU_C_APP_ERASE   7'h20
`define ENPCU_C_APG_ERASE   7'h22
`define ENPCU_C_APG_WRITE   7'h24
`define ENPCU_C_APG_EW      7'h25
`define ENPCU_C_APP_CRC     7'h38
`define ENPCU_C_BOOT_ERASE  7'h68
`define ENPCU_C_BPG_ERASE   7'h2A
`define ENPCU_C_BPG_WRITE   7'h2C
`define ENPCU_C_BPG_EW      7'h2D
`define ENPCU_C_BOOT_CRC    7'h39
`define ENPCU_C_USIG_READ   7'h01
`define ENPCU_C_USIG_ERASE  7'h18
`define ENPCU_C_USIG_WRITE  7'h1A
`define ENPCU_C_CAL_READ    7'h02
`define ENPCU_C_FUSE_READ   7'h07
`define ENPCU_C_FUSE_WRITE  7'h4C
`define ENPCU_C_LOCK_WRITE  7'h08
`define ENPCU_C_EBUF_LOAD   7'h33
`define ENPCU_C_EBUF_ERASE  7'h36
`define ENPCU_C_EE_ERASE    7'h30
`define ENPCU_C_EPG_ERASE   7'h32
`define ENPCU_C_EPG_WRITE   7'h34
`define ENPCU_C_EPG_EW      7'h35
`define ENPCU_C_EE_READ     7'h06

// Linear debug address map (byte addresses) and region codes
`define ENPCU_BASE_FLASH    24'h80_0000
`define ENPCU_BASE_EEPROM   24'h8C_0000
`define ENPCU_BASE_FUSE     24'h8F_0020
`define ENPCU_BASE_SIG      24'h8E_0200
`define ENPCU_RG_NONE       3'h0
`define ENPCU_RG_FLASH      3'h1
`define ENPCU_RG_EEPROM     3'h2
`define ENPCU_RG_FUSE       3'h3
`define ENPCU_RG_SIG        3'h4
`define ENPCU_PAGE_BITS     9

`endif

// >>> enpcu_top.v
// Nonvolatile store command unit as reached from the program/debug port
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Programmer writes signature, key, then polls enable
// R2: Memory path usable only while enabled flag set
// R3: All memories mapped into linear debug space
// R4: Programmer loads matching command before any access
// R5: All debug addresses are byte addresses
// R6: Page buffer slot from low address bits
// R7: Programmer keeps loads and writes within page
// R8: Busy erase or write blocks every read
// R9: Execute bit starts action-triggered commands
// R10: Debug bus read runs read-triggered command
// R11: Debug bus write runs write-triggered command
// R12: Both locks set allow only chip erase, CRC
// R13: Chip erase by execute, busy, fuse keeps EEPROM
// R14: Flash buffer load by write, erase by execute
// R15: Flash page erase/write by bus write, busy
// R16: Flash, application, boot checksum commands set busy
// R17: Application section erase/page commands by write, busy
// R18: Boot section erase/page commands by write, busy
// R19: Signature/calibration read by read, signature erase/write busy
// R20: EEPROM buffer load by write, erase by execute
// R21: EEPROM erase by execute, page commands by write
// R22: Chip erase, flash checksum drop the enabled flag
// R23: Zero or unknown command does nothing
//////////////////////////////////////////////////////////////////////////////
`include "enpcu_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Register map, one aligned 32-bit word each
//   0x00 reset signature, bits 7:0, read back
//   0x04 key, write only, reads zero
//   0x08 status: bit 0 enabled, 1 busy, 2 refused
//   0x0C command code, bits 6:0, read back
//   0x10 control A: bit 0 execute, reads zero
//   0x14 data: back end word of last execute
// Unmapped offsets answer with error, drop writes
//
// Enabling sequence
//   Signature first, then the key; a key written
//   without the signature in place is not kept
//   Enabled rises one edge after the key write
//   Any other signature value drops it again
//   Trade-off: one extra cycle keeps it a flop
//
// Trigger classes
//   Execute: control A write with bit 0 set
//   Read: a debug bus load while enabled
//   Write: a debug bus store while enabled
//   None: zero or unknown codes never start
//   Execute wins over a debug request
//
// Debug bus handshake
//   Request fields held until ack
//   Start pulse one cycle after the take
//   Ack one cycle after back end done
//   Refused requests: ack with error next cycle
//   Ack and error last one cycle each
//   Request high on the ack cycle not retaken
//
// Busy handling
//   Busy follows the command table, set at start
//   Cleared at the edge after done
//   Non-busy loads still wait for done
//   New requests stall while a command that keeps the path runs,
//   which keeps reads away from a busy store
//
// Lock handling
//   Both locks: only chip erase and flash sum
//   Anything else sets the refused flag
//   Refused cleared by writing 1 to status bit 2
//   A refusal in the clearing cycle wins
//
// Bus loss
//   Chip erase and flash sum take the path away
//   Enabled reads zero until back end done
//   Requests meanwhile get an error ack
//
// Address handling
//   Full byte address selects the region
//   Low nine bits pick the page buffer slot
//   Page crossings not corrected here; the
//   programmer keeps accesses inside a page
//
// Back end outputs
//   Command, address, data are flops held
//   until the next start; address fields move
//   only for debug-triggered commands, so an
//   execute sees the last debug address
//   Keep-EEPROM follows the fuse, chip erase only
//
// Limitations
//   One outstanding request at a time
//   No wait states on the register bus
//   Read data latched in the setup cycle
//   Flash word pairing left to the back end
//   Key value is a parameter, arbitrary default
//   No interrupt; software polls status
//   A refused command never sets busy
//
// Reset
//   Synchronous, active low; flops to zero
//   First request at the first edge after it

module enpcu_top #(
   parameter [31:0] KEY_VALUE = 32'h0123_4567   // Arbitrary key value
) (
   input  wire        clk,
   input  wire        rstn,
   // APB slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Debug memory bus from the program/debug port
   input  wire        dbg_req,
   input  wire        dbg_we,
   input  wire [23:0] dbg_addr,
   input  wire [7:0]  dbg_wdata,
   output reg  [7:0]  dbg_rdata,
   output reg         dbg_ack,
   output reg         dbg_err,
   // Lock bits and fuse
   input  wire        read_lock,
   input  wire        write_lock,
   input  wire        eeprom_preserve_fuse,
   // Memory back end
   output reg         mem_start,
   output reg  [6:0]  mem_cmd,
   output reg  [23:0] mem_addr,
   output reg  [2:0]  mem_region,
   output reg  [8:0]  mem_buf_idx,
   output reg  [7:0]  mem_wdata,
   output reg         mem_keep_eeprom,
   input  wire        mem_done,
   input  wire [31:0] mem_rdata
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   //////////////////////////////////////////////////////////////////////////
   // Command decode: {trigger class, sets busy}
   function [2:0] cmd_class;
      input [6:0] c;
      begin
         case (c)
            `ENPCU_C_CHIP_ERASE : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};   // see R13
            `ENPCU_C_READ_STORE,
            `ENPCU_C_FUSE_READ,
            `ENPCU_C_EE_READ    : cmd_class = {`ENPCU_TRG_READ, 1'b0};
            `ENPCU_C_FBUF_LOAD  : cmd_class = {`ENPCU_TRG_WRITE, 1'b0};  // see R14
            `ENPCU_C_FBUF_ERASE : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};   // see R14
            `ENPCU_C_FPG_ERASE,
            `ENPCU_C_FPG_WRITE,
            `ENPCU_C_FPG_EW     : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};  // see R15
            `ENPCU_C_FLASH_CRC,
            `ENPCU_C_APP_CRC,
            `ENPCU_C_BOOT_CRC   : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};   // see R16
            `ENPCU_C_APP_ERASE,
            `ENPCU_C_APG_ERASE,
            `ENPCU_C_APG_WRITE,
            `ENPCU_C_APG_EW     : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};  // see R17
            `ENPCU_C_BOOT_ERASE,
            `ENPCU_C_BPG_ERASE,
            `ENPCU_C_BPG_WRITE,
            `ENPCU_C_BPG_EW     : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};  // see R18
            `ENPCU_C_USIG_READ,
            `ENPCU_C_CAL_READ   : cmd_class = {`ENPCU_TRG_READ, 1'b0};   // see R19
            `ENPCU_C_USIG_ERASE,
            `ENPCU_C_USIG_WRITE : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};  // see R19
            `ENPCU_C_FUSE_WRITE : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};
            `ENPCU_C_LOCK_WRITE : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};
            `ENPCU_C_EBUF_LOAD  : cmd_class = {`ENPCU_TRG_WRITE, 1'b0};  // see R20
            `ENPCU_C_EBUF_ERASE : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};   // see R20
            `ENPCU_C_EE_ERASE   : cmd_class = {`ENPCU_TRG_EXEC, 1'b1};   // see R21
            `ENPCU_C_EPG_ERASE,
            `ENPCU_C_EPG_WRITE,
            `ENPCU_C_EPG_EW     : cmd_class = {`ENPCU_TRG_WRITE, 1'b1};  // see R21
            default             : cmd_class = {`ENPCU_TRG_NONE, 1'b0};   // see R23
         endcase
      end
   endfunction

   // Region from the full byte address; order matters, highest base first
   function [2:0] addr_region;
      input [23:0] a;
      begin
         if (a >= `ENPCU_BASE_FUSE)
            addr_region = `ENPCU_RG_FUSE;
         else if (a >= `ENPCU_BASE_SIG)
            addr_region = `ENPCU_RG_SIG;
         else if (a >= `ENPCU_BASE_EEPROM)
            addr_region = `ENPCU_RG_EEPROM;
         else if (a >= `ENPCU_BASE_FLASH)
            addr_region = `ENPCU_RG_FLASH;
         else
            addr_region = `ENPCU_RG_NONE;
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // State
   reg  [7:0]  reset_r;
   reg         key_ok_r;
   reg         en_r;
   reg         off_r;
   reg         busy_r;
   reg         refused_r;
   reg  [6:0]  cmd_r;
   reg  [31:0] data_r;
   reg         state_r;
   reg         src_dbg_r;
   reg         src_rd_r;

   wire        apb_acc   = psel & penable;
   wire        apb_wr    = apb_acc & pwrite;
   wire        enabled   = en_r & ~off_r;
   wire        sig_ok    = (reset_r == `ENPCU_RESET_SIG);
   wire [2:0]  cls       = cmd_class(cmd_r);
   wire [1:0]  trg       = cls[2:1];
   wire        lock_ok   = ~(read_lock & write_lock) | (cmd_r == `ENPCU_C_CHIP_ERASE) |
                           (cmd_r == `ENPCU_C_FLASH_CRC);                  // see R12
   wire        wr_ctl_a  = apb_wr & (paddr == `ENPCU_OFS_CTL_A);
   // No change protection for external programming: a plain write starts it
   wire        exec_hit  = (state_r == ST_IDLE) & wr_ctl_a & pwdata[`ENPCU_CTL_A_EX_BIT] &
                           (trg == `ENPCU_TRG_EXEC);                       // see R9
   wire        dbg_new   = dbg_req & ~dbg_ack;
   wire        dbg_match = dbg_we ? (trg == `ENPCU_TRG_WRITE) : (trg == `ENPCU_TRG_READ);
   wire        dbg_hit   = (state_r == ST_IDLE) & dbg_new & enabled & ~exec_hit;
   wire        go        = exec_hit | (dbg_hit & dbg_match);               // see R10 R11
   wire        refuse    = go & ~lock_ok;

   //////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, read data latched in the setup cycle
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `ENPCU_OFS_RESET) | (a == `ENPCU_OFS_KEY) | (a == `ENPCU_OFS_STATUS) |
                  (a == `ENPCU_OFS_CMD) | (a == `ENPCU_OFS_CTL_A) | (a == `ENPCU_OFS_DATA);
      end
   endfunction

   assign pready  = 1'b1;
   assign pslverr = apb_acc & ~mapped(paddr);   // Unmapped: error, write dropped

   // Read mux into a flop so prdata is stable in the access cycle
   always @(posedge clk) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         case (paddr)
            `ENPCU_OFS_RESET  : prdata <= {24'h00_0000, reset_r};
            `ENPCU_OFS_STATUS : prdata <= {29'h0000_0000, refused_r, busy_r, enabled}; // see R2
            `ENPCU_OFS_CMD    : prdata <= {25'h000_0000, cmd_r};
            `ENPCU_OFS_DATA   : prdata <= data_r;
            default           : prdata <= 32'h0000_0000;   // Key and control A read zero
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Enable handshake: signature, then key, enabled one cycle after the key
   always @(posedge clk) begin
      if (!rstn) begin
         reset_r  <= `ENPCU_RESET_RST;
         key_ok_r <= 1'b0;
         en_r     <= 1'b0;
      end else begin
         if (apb_wr & (paddr == `ENPCU_OFS_RESET))
            reset_r <= pwdata[7:0];
         if (apb_wr & (paddr == `ENPCU_OFS_KEY))
            key_ok_r <= (pwdata == KEY_VALUE) & sig_ok;                    // see R1
         else if (!sig_ok)
            key_ok_r <= 1'b0;
         // Leaving the signature drops the interface one edge after reset_r changes
         en_r <= key_ok_r & sig_ok;                                        // see R2
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command register and refusal flag; refusal set wins over clear
   always @(posedge clk) begin
      if (!rstn) begin
         cmd_r     <= `ENPCU_CMD_RST;
         refused_r <= 1'b0;
      end else begin
         if (apb_wr & (paddr == `ENPCU_OFS_CMD))
            cmd_r <= pwdata[6:0];
         if (refuse)
            refused_r <= 1'b1;                                             // see R12
         else if (apb_wr & (paddr == `ENPCU_OFS_STATUS) & pwdata[`ENPCU_ST_REFUSED_BIT])
            refused_r <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sequencer: launch one command, hold until the back end reports done
   always @(posedge clk) begin
      if (!rstn) begin
         state_r         <= ST_IDLE;
         busy_r          <= 1'b0;
         off_r           <= 1'b0;
         src_dbg_r       <= 1'b0;
         src_rd_r        <= 1'b0;
         data_r          <= `ENPCU_DATA_RST;
         mem_start       <= 1'b0;
         mem_cmd         <= `ENPCU_CMD_RST;
         mem_addr        <= 24'h00_0000;
         mem_region      <= `ENPCU_RG_NONE;
         mem_buf_idx     <= 9'h000;
         mem_wdata       <= 8'h00;
         mem_keep_eeprom <= 1'b0;
         dbg_ack         <= 1'b0;
         dbg_err         <= 1'b0;
         dbg_rdata       <= 8'h00;
      end else begin
         mem_start <= 1'b0;
         dbg_ack   <= 1'b0;
         dbg_err   <= 1'b0;
         case (state_r)
            ST_IDLE : begin
               if (go & lock_ok) begin
                  state_r     <= ST_RUN;
                  mem_start   <= 1'b1;
                  mem_cmd     <= cmd_r;
                  busy_r      <= cls[0];                                   // see R13 R15 R16
                  src_dbg_r   <= ~exec_hit;
                  src_rd_r    <= ~exec_hit & ~dbg_we;
                  // Chip erase and whole-flash checksum take the bus away
                  off_r       <= (cmd_r == `ENPCU_C_CHIP_ERASE) |
                                 (cmd_r == `ENPCU_C_FLASH_CRC);            // see R22
                  mem_keep_eeprom <= (cmd_r == `ENPCU_C_CHIP_ERASE) &
                                     eeprom_preserve_fuse;                 // see R13
                  if (!exec_hit) begin
                     mem_addr    <= dbg_addr;                              // see R3 R5
                     mem_region  <= addr_region(dbg_addr);                 // see R3
                     mem_buf_idx <= dbg_addr[`ENPCU_PAGE_BITS-1:0];        // see R6
                     mem_wdata   <= dbg_wdata;
                  end
               end else if (dbg_hit) begin
                  // Wrong direction, no-op or unknown code: no effect; locked: refused flag set
                  dbg_ack <= 1'b1;                                         // see R23
                  dbg_err <= 1'b1;
               end
            end
            ST_RUN : begin
               // Debug accesses wait here unless the path is taken away, so reads stall while busy
               if (mem_done) begin                                         // see R8
                  state_r <= ST_IDLE;
                  busy_r  <= 1'b0;
                  off_r   <= 1'b0;
                  if (src_dbg_r)
                     dbg_ack <= 1'b1;
                  if (src_rd_r)
                     dbg_rdata <= mem_rdata[7:0];                          // see R10
                  if (!src_dbg_r)
                     data_r <= mem_rdata;                                  // Checksum result
               end
            end
            default : state_r <= ST_IDLE;
         endcase
         // Disabled interface answers at once with an error
         if (dbg_new & ~enabled & ~(state_r == ST_RUN & src_dbg_r)) begin  // see R2 R22
            dbg_ack <= 1'b1;
            dbg_err <= 1'b1;
         end
      end
   end

endmodule

// >>> enpcu_checker.sv
// Port assertions for the command unit
module enpcu_checker (
   input logic        clk,
   input logic        rstn,
   input logic        dbg_req,
   input logic        dbg_we,
   input logic [7:0]  dbg_rdata,
   input logic        dbg_ack,
   input logic        dbg_err,
   input logic        read_lock,
   input logic        write_lock,
   input logic        eeprom_preserve_fuse,
   input logic        mem_start,
   input logic [6:0]  mem_cmd,
   input logic [23:0] mem_addr,
   input logic [8:0]  mem_buf_idx,
   input logic        mem_keep_eeprom,
   input logic        mem_done,
   input logic [31:0] mem_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic run_r;
   //////////////////////////////////////////////////////////////////////////////
   // Back end busy from start to done, to catch overlapping starts
   always_ff @(posedge clk) begin
      run_r <= !rstn ? 1'b0 : mem_start ? 1'b1 : mem_done ? 1'b0 : run_r;
   end
   // Steps of a debug load: back end done, then good ack
   sequence s_done;
      mem_done;
   endsequence
   sequence s_good_rd;
      dbg_ack && !dbg_err && !dbg_we;
   endsequence
   a_ack_pulse: assert property (dbg_ack |=> !dbg_ack)
      else $error("ack held longer than one cycle");
   a_err_ack: assert property (dbg_err |-> dbg_ack)
      else $error("error flag without ack");
   a_ack_req: assert property (dbg_ack |-> $past(dbg_req))
      else $error("ack without a request");
   a_read_data: assert property (s_done ##1 s_good_rd |-> dbg_rdata == $past(mem_rdata[7:0]))
      else $error("read byte differs from back end");
   a_good_done: assert property (dbg_ack && !dbg_err |-> $past(mem_done))
      else $error("good ack before back end done");
   a_no_overlap: assert property (run_r && !mem_done |-> !mem_start)
      else $error("start while back end busy");
   a_buf_low: assert property (mem_start && mem_cmd inside {7'h23, 7'h33} |-> mem_buf_idx == mem_addr[8:0])
      else $error("buffer slot not from low address bits");
   a_lock_only: assert property (mem_start && read_lock && write_lock |-> mem_cmd inside {7'h40, 7'h78})
      else $error("command started under full lock");
   a_keep_fuse: assert property (mem_start && mem_cmd == 7'h40 |-> mem_keep_eeprom == eeprom_preserve_fuse)
      else $error("eeprom keep does not follow fuse");
   a_nop_idle: assert property (mem_start |-> mem_cmd != 7'h00)
      else $error("no-operation code started back end");
endmodule

// >>> enpcu_mem_model.sv
// Behavioural memory back end answering start pulses
module enpcu_mem_model (
   input  logic        clk,
   input  logic        rstn,
   input  logic        fast,
   input  logic        mem_start,
   input  logic [23:0] mem_addr,
   output logic        mem_done,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_r;
   logic       run_r;
   //////////////////////////////////////////////////////////////////////////////
   // Count to done; data toggles outside done so stale reads show
   always @(posedge clk) begin
      mem_done <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rstn) begin
         run_r <= 1'b0;
         mem_rdata <= 32'h0;
      end else if (mem_start) begin
         run_r <= 1'b1;
         cnt_r <= fast ? 4'h1 : 4'h8;
      end else if (run_r) begin
         cnt_r <= cnt_r - 4'h1;
         if (cnt_r == 4'h1) begin
            run_r <= 1'b0;
            mem_done <= 1'b1;
            mem_rdata <= {8'h00, mem_addr ^ 24'h5A5A5A};
         end
      end
   end
endmodule

// >>> tb_enpcu_top.sv
// Self-checking bench for the command unit
module tb_enpcu_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, dbg_req = 0, dbg_we = 0;
   logic read_lock = 0, write_lock = 0, eeprom_preserve_fuse = 0, fast = 0, e;
   logic [7:0] paddr = 0, dbg_wdata = 0, dbg_rdata, b;
   logic [31:0] pwdata = 0, prdata, mem_rdata, r;
   logic [23:0] dbg_addr = 0, mem_addr;
   logic [6:0] mem_cmd;
   logic [2:0] mem_region;
   logic [8:0] mem_buf_idx;
   logic [7:0] mem_wdata;
   logic pready, pslverr, dbg_ack, dbg_err, mem_start, mem_keep_eeprom, mem_done;
   int n_errors = 0, checks = 0;
   logic [6:0] wc[18] = '{7'h2B, 7'h2E, 7'h2F, 7'h20, 7'h22, 7'h24, 7'h25, 7'h68, 7'h2A,
                          7'h2C, 7'h2D, 7'h18, 7'h1A, 7'h32, 7'h34, 7'h35, 7'h23, 7'h33};
   logic [6:0] xc[7] = '{7'h40, 7'h26, 7'h78, 7'h38, 7'h39, 7'h36, 7'h30};
   enpcu_top dut_u (.*);
   enpcu_mem_model mem_u (.clk(clk), .rstn(rstn), .fast(fast), .mem_start(mem_start),
                          .mem_addr(mem_addr), .mem_done(mem_done), .mem_rdata(mem_rdata));
   //////////////////////////////////////////////////////////////////////////////
   // Clock
   initial forever #20 clk = ~clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // APB transfer, held until pready sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Debug bus byte transfer, held until ack
   task dbg(input logic we, input logic [23:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      {dbg_req, dbg_we, dbg_addr, dbg_wdata} <= {1'b1, we, a, d};
      n = 0;
      do @(posedge clk); while (dbg_ack !== 1'b1 && ++n < 100);
      b = dbg_rdata;
      e = dbg_err;
      dbg_req <= 1'b0;
   endtask
   task ex(input logic [6:0] c);
      apb(1, 8'h0C, {25'h0, c});
      apb(1, 8'h10, 32'h1);
   endtask
   // Poll until enabled and not busy
   task idle;
      int n;
      n = 0;
      do apb(0, 8'h08, 0); while (r[1:0] !== 2'b01 && ++n < 40);
      chk(r[1:0], 2'b01, "status idle");
   endtask
   task results;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Before enabling: clean status, refused bus, unmapped offset
   task t_start;
      apb(0, 8'h08, 0);
      chk(r, 32'h0, "status reset");
      apb(0, 8'h20, 0);
      chk(e, 1'b1, "unmapped slverr");
      dbg(0, 24'h800000, 0);
      chk(e, 1'b1, "disabled err");
      apb(1, 8'h00, 32'h59);
      apb(1, 8'h04, 32'h0123_4567);
      idle;
   endtask
   // Read-triggered codes across two regions
   task t_read;
      foreach (xc[i]) if (i < 3) begin
         apb(1, 8'h0C, {25'h0, i == 0 ? 7'h43 : i == 1 ? 7'h01 : 7'h02});
         dbg(0, i == 2 ? 24'h8C0010 : 24'h800123, 0);
         chk(e, 1'b0, "read err");
         chk(b, (i == 2 ? 8'h10 : 8'h23) ^ 8'h5A, "read byte");
         chk(mem_region, i == 2 ? 3'h2 : 3'h1, "region");
         chk(mem_addr, i == 2 ? 24'h8C0010 : 24'h800123, "byte addr");
      end
   endtask
   // Every write-triggered code except fuse write, page buffer slot from low bits
   task t_write;
      fast <= 1'b1;
      foreach (wc[i]) begin
         apb(1, 8'h0C, {25'h0, wc[i]});
         dbg(1, 24'h8001FF, 8'hC3);
         chk(e, 1'b0, "write err");
         chk({mem_cmd, mem_wdata}, {wc[i], 8'hC3}, "write cmd");
         chk(mem_buf_idx, 9'h1FF, "buf slot");
      end
      fast <= 1'b0;
   endtask
   // Execute-triggered codes: busy, enable drop for chip erase and flash sum
   task t_exec;
      eeprom_preserve_fuse <= 1'b1;
      foreach (xc[i]) begin
         ex(xc[i]);
         apb(0, 8'h08, 0);
         chk(r[2:0], {2'b01, !(xc[i] inside {7'h40, 7'h78})}, "exec status");
         chk(mem_cmd, xc[i], "exec cmd");
         if (i == 0) chk(mem_keep_eeprom, 1'b1, "keep eeprom");
         idle;
         if (i == 2) begin
            apb(0, 8'h14, 0);
            chk(r, {8'h00, 24'h8001FF ^ 24'h5A5A5A}, "flash sum data");
         end
      end
   endtask
   // Wrong trigger, no-op, unknown code and reads held off while busy
   task t_bad;
      apb(1, 8'h0C, 32'h43);
      dbg(1, 24'h800000, 8'h11);
      chk(e, 1'b1, "wrong trigger");
      apb(1, 8'h0C, 32'h00);
      dbg(0, 24'h800000, 0);
      chk(e, 1'b1, "nop err");
      ex(7'h7F);
      apb(0, 8'h08, 0);
      chk(r[1:0], 2'b01, "unknown idle");
      ex(7'h26);
      apb(1, 8'h0C, 32'h43);
      dbg(0, 24'h800005, 0);
      chk({e, b}, {1'b0, 8'h05 ^ 8'h5A}, "read after busy");
   endtask
   // Full lock: buffer erase and page erase refused, flash sum accepted
   task t_lock;
      {read_lock, write_lock} <= 2'b11;
      ex(7'h26);
      apb(0, 8'h08, 0);
      chk(r[2:0], 3'b101, "locked refuse");
      apb(1, 8'h0C, 32'h2B);
      dbg(1, 24'h800000, 0);
      chk(e, 1'b1, "locked write");
      ex(7'h78);
      idle;
      apb(1, 8'h08, 32'h4);
      apb(0, 8'h08, 0);
      chk(r[2:0], 3'b001, "refused clear");
      {read_lock, write_lock} <= 2'b00;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_start;
      t_read;
      t_write;
      t_exec;
      t_bad;
      t_lock;
      results;
   end
   initial begin
      #400000;
      n_errors++;
      $display("unexpected timeout");
      results;
   end
endmodule
bind enpcu_top enpcu_checker chk_u (.*);
